// ==== logic/sfd_pkg.sv ====
// =====================================================
// Shared constants for servo format decode
// =====================================================
package sfd_pkg;

   // =====================================================
   // Clock and timing
   // =====================================================
   localparam int CLK_MHZ        = 40;                                 // System clock rate
   localparam int ONESHOT_NS     = 2500;                               // Index stretch length
   localparam int ONESHOT_CYC    = (ONESHOT_NS * CLK_MHZ + 999) / 1000; // Least time, rounded up
   localparam int OS_W           = 7;                                  // One-shot counter width
   localparam int BYTE_DIV       = 12;                                 // Servo clocks per byte clock
   localparam int BDIV_W         = 4;                                  // Byte divider width

   // =====================================================
   // Format pattern decoding
   // =====================================================
   localparam int       PAT_LEN  = 5;                                  // Pattern shift stages
   localparam bit [4:0] PAT_IDX  = 5'h1B;                              // Index code 11011
   localparam bit [4:0] PAT_OGB  = 5'h17;                              // Outer guard band 10111
   localparam bit [4:0] PAT_IGB  = 5'h1D;                              // Inner guard band 11101
   localparam bit [4:0] PAT_DATA = 5'h15;                              // Data zone code 10101
   localparam bit [4:0] PAT_RST  = 5'h00;                              // Pattern reset value

   // =====================================================
   // Sector counter
   // =====================================================
   localparam int        SEC_W   = 12;                                 // Sector counter width
   localparam bit [11:0] SEC_MAX = 12'hFFF;                            // Maximum count
   localparam int        REV_BYTES = 13440;                            // Byte clocks per revolution

   // =====================================================
   // Tribit interval sequence, Gray coded
   // =====================================================
   typedef enum logic [1:0] {
      SFD_IV_PRESET = 2'b00,                                           // Sample preset interval
      SFD_IV_SLOT1  = 2'b01,                                           // First position slot
      SFD_IV_SLOT2  = 2'b11,                                           // Second position slot
      SFD_IV_XFER   = 2'b10                                            // Hold transfer interval
   } sfd_ival_t;

endpackage

// ==== logic/sfd_sec_if.sv ====
`timescale 1ns/1ps
// =====================================================
// Link between decoder top and sector counter
// =====================================================
interface sfd_sec_if;
   logic                     byte_tick;   // One pulse per data byte
   logic                     index_rise;  // Index latch just set
   logic [sfd_pkg::SEC_W-1:0] preset;     // Sector preset value
   logic                     sector;      // Sector pulse, registered
   logic [sfd_pkg::SEC_W-1:0] count;      // Current count

   // Counter side
   modport ctr (
      input  byte_tick,
      input  index_rise,
      input  preset,
      output sector,
      output count
   );

   // Decoder side
   modport user (
      output byte_tick,
      output index_rise,
      output preset,
      input  sector,
      input  count
   );
endinterface

// ==== logic/sfd_sector_count.sv ====
`timescale 1ns/1ps
// =====================================================
// Sector counter
// =====================================================
module sfd_sector_count (
   input  wire logic clk,
   input  wire logic rst_n,
   sfd_sec_if.ctr    sec
);
   import sfd_pkg::*;

   logic [SEC_W-1:0] cnt_r;     // Byte count within sector
   logic [SEC_W-1:0] cnt_nxt;   // Next count
   logic             sec_r;     // Sector pulse
   logic             at_max;    // Count at maximum

   assign at_max = (cnt_r == SEC_MAX);

   // Next count selection
   always_comb begin
      cnt_nxt = cnt_r;
      // RL17 index restarts count
      if (sec.index_rise) begin
         cnt_nxt = sec.preset;
      // RL18 reload after maximum
      end else if (sec.byte_tick && at_max) begin
         cnt_nxt = sec.preset;
      // RL16 count byte clocks
      end else if (sec.byte_tick) begin
         cnt_nxt = cnt_r + 12'h001;
      end
   end

   // Counter and sector pulse registers
   always_ff @(posedge clk) begin
      // RL22 reset loads preset
      if (!rst_n) begin
         cnt_r <= sec.preset;
         sec_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         // RL16 pulse only on the tick reaching maximum
         sec_r <= sec.byte_tick && (cnt_nxt == SEC_MAX) && !sec.index_rise;
      end
   end

   assign sec.sector = sec_r;
   assign sec.count  = cnt_r;
endmodule

// ==== logic/sfd_top.sv ====
`timescale 1ns/1ps
// Function
// RL1 - five-stage shift register records servo byte types
// RL2 - data-bit flag set by data, cleared by sync
// RL3 - shift on leading edge of shift clock
// RL4 - decode only while half-byte window active
// RL5 - 11011 pulses index and recognized code
// RL6 - 10111 pulses outer guard and recognized
// RL7 - 11101 pulses inner guard and recognized
// RL8 - 10101 pulses only recognized code
// RL9 - index fires 2.5 us one-shot
// RL10 - index latch set with byte clock
// RL11 - recognized code forces gate phase alignment
// RL12 - slope level swaps the peak gates
// RL13 - phase reference only for sync bits
// RL14 - recovered clock divided by four
// RL15 - phase flip-flop set/reset by narrow pulses
// RL16 - sector counter pulses at 4095
// RL17 - index resets sector counter
// RL18 - preset reload after maximum count
// RL19 - byte clock from servo clock
// RL20 - preset comes from board switches
// RL21 - processor watches guard band pulses
// RL22 - reset clears state, loads preset; the counter loads 0, as the preset synchroniser is cleared too
module sfd_top (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      zero_cross_det,
   input  wire logic                      sync_slot,
   input  wire logic                      servo_data_clk,
   input  wire logic                      tribit_clk,
   input  wire logic                      slope_sel,
   input  wire logic                      rec_clk,
   input  wire logic                      servo_clk,
   input  wire logic [sfd_pkg::SEC_W-1:0] sector_preset,
   output logic                           index_en,
   output logic                           valid_decode_n,
   output logic                           outer_gb_n,
   output logic                           inner_gb_n,
   output logic                           index_out,
   output logic                           sector_out,
   output logic                           phase_ref_pulse_n,
   output logic                           divided_sync_rate_clock,
   output logic                           phase_ff,
   output logic                           preset_gate,
   output logic                           peak_a_gate,
   output logic                           peak_b_gate,
   output logic                           xfer_gate
);
   import sfd_pkg::*;

   // =====================================================
   // Functions
   // =====================================================

   // Rising edge from current and previous level
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   // =====================================================
   // Input synchronisers
   // =====================================================
   localparam int NIN = 7;                 // Single-bit pin count

   logic [NIN-1:0]   pin_vec;              // Raw pins
   logic [NIN-1:0]   s1_r;                 // First stage
   logic [NIN-1:0]   s2_r;                 // Second stage
   logic [NIN-1:0]   s3_r;                 // Edge history
   logic [SEC_W-1:0] pre_s1_r;             // Preset first stage
   logic [SEC_W-1:0] pre_s2_r;             // Preset second stage

   assign pin_vec = {servo_clk, rec_clk, slope_sel, tribit_clk,
                     servo_data_clk, sync_slot, zero_cross_det};

   // Two-stage sync plus history
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r     <= '0;
         s2_r     <= '0;
         s3_r     <= '0;
         pre_s1_r <= '0;
         pre_s2_r <= '0;
      end else begin
         s1_r     <= pin_vec;
         s2_r     <= s1_r;
         s3_r     <= s2_r;
         pre_s1_r <= sector_preset;
         pre_s2_r <= pre_s1_r;
      end
   end

   // =====================================================
   // Edge and level decode
   // =====================================================
   wire zc_rise      = rise(s2_r[0], s3_r[0]);   // Any bit detected
   wire slot_lvl     = s2_r[1];                  // Sync slot window
   wire sdclk_rise   = rise(s2_r[2], s3_r[2]);   // Shift clock edge
   wire win_lvl      = s2_r[3];                  // Half-byte window
   wire win_rise     = rise(s2_r[3], s3_r[3]);   // Window opening
   wire slope_lvl    = s2_r[4];                  // Slope select
   wire rclk_rise    = rise(s2_r[5], s3_r[5]);   // Recovered clock edge
   wire sclk_rise    = rise(s2_r[6], s3_r[6]);   // Servo clock edge
   // RL13 sync bits only
   wire sync_bit     = zc_rise & slot_lvl;       // Sync detection
   wire data_bit     = zc_rise & ~slot_lvl;      // Servo data detection

   // =====================================================
   // Data-bit flag and pattern register
   // =====================================================
   logic               dbit_r;           // Servo data bit flag
   logic [PAT_LEN-1:0] pat_r;            // Last five byte types
   logic [PAT_LEN-1:0] pat_nxt;          // Shifted pattern

   assign pat_nxt = {pat_r[PAT_LEN-2:0], dbit_r};

   // Flag and shift register
   always_ff @(posedge clk) begin
      // RL22 clear pattern
      if (!rst_n) begin
         dbit_r <= 1'b0;
         pat_r  <= PAT_RST;
      end else begin
         // RL2 set wins over clear
         if (data_bit) begin
            dbit_r <= 1'b1;
         end else if (sync_bit) begin
            dbit_r <= 1'b0;
         end
         // RL1 RL3 shift on clock edge
         if (sdclk_rise) begin
            pat_r <= pat_nxt;
         end
      end
   end

   // =====================================================
   // Pattern decoder
   // =====================================================
   // RL4 window gates decode
   wire dec_en  = win_lvl & win_rise;             // One decode per byte
   wire hit_idx = dec_en & (pat_r == PAT_IDX);    // Index code
   wire hit_ogb = dec_en & (pat_r == PAT_OGB);    // Outer guard code
   wire hit_igb = dec_en & (pat_r == PAT_IGB);    // Inner guard code
   wire hit_dat = dec_en & (pat_r == PAT_DATA);   // Data zone code
   wire hit_any = hit_idx | hit_ogb | hit_igb | hit_dat;

   logic idx_en_r;                 // Index enable pulse
   logic valid_n_r;                // Recognized code, low
   logic ogb_n_r;                  // Outer guard pulse, low
   logic igb_n_r;                  // Inner guard pulse, low

   // Decoder output pulses
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idx_en_r  <= 1'b0;
         valid_n_r <= 1'b1;
         ogb_n_r   <= 1'b1;
         igb_n_r   <= 1'b1;
      end else begin
         // RL5 index pulse
         idx_en_r  <= hit_idx;
         // RL6 RL7 guard band pulses
         ogb_n_r   <= ~hit_ogb;
         igb_n_r   <= ~hit_igb;
         // RL8 recognized for all codes
         valid_n_r <= ~hit_any;
      end
   end

   // =====================================================
   // Index stretcher and latch
   // =====================================================
   logic [OS_W-1:0]   os_cnt_r;     // One-shot remaining cycles
   logic              index_r;      // Index latch
   logic              index_d_r;    // Latch history
   logic [BDIV_W-1:0] bdiv_r;       // Servo clock divider
   logic              btick_r;      // Byte clock pulse

   wire os_act  = (os_cnt_r != '0);              // One-shot output
   wire bdiv_wr = (bdiv_r == BDIV_W'(BYTE_DIV - 1));

   // One-shot and index latch
   always_ff @(posedge clk) begin
      // RL22 clear one-shot and latch
      if (!rst_n) begin
         os_cnt_r  <= '0;
         index_r   <= 1'b0;
         index_d_r <= 1'b0;
      end else begin
         index_d_r <= index_r;
         // RL9 fire stretcher
         if (idx_en_r) begin
            os_cnt_r <= OS_W'(ONESHOT_CYC);
         end else if (os_act) begin
            os_cnt_r <= os_cnt_r - 7'h01;
         end
         // RL10 set with byte clock
         if (!os_act) begin
            index_r <= 1'b0;
         end else if (btick_r) begin
            index_r <= 1'b1;
         end
      end
   end

   // Byte clock divider
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bdiv_r  <= '0;
         btick_r <= 1'b0;
      end else begin
         // RL19 divide servo clock
         btick_r <= sclk_rise & bdiv_wr;
         if (sclk_rise) begin
            bdiv_r <= bdiv_wr ? '0 : bdiv_r + 4'h1;
         end
      end
   end

   // =====================================================
   // Sector counter
   // =====================================================
   sfd_sec_if sec_if ();

   assign sec_if.byte_tick  = btick_r;
   // RL17 latch set restarts count
   assign sec_if.index_rise = rise(index_r, index_d_r);
   // RL20 switch preset
   assign sec_if.preset     = pre_s2_r;

   sfd_sector_count u_sec (
      .clk   (clk),
      .rst_n (rst_n),
      .sec   (sec_if)
   );

   // =====================================================
   // Divided clock and phase comparison
   // =====================================================
   sfd_ival_t iv_r;          // Current tribit interval
   sfd_ival_t iv_nxt;        // Next interval
   logic      pref_n_r;      // Phase reference, low
   logic      phase_r;       // Phase comparison flip-flop
   logic      div_r;         // Divided clock output

   // RL14 divide by four
   always_comb begin
      case (iv_r)
         SFD_IV_PRESET: iv_nxt = SFD_IV_SLOT1;
         SFD_IV_SLOT1:  iv_nxt = SFD_IV_SLOT2;
         SFD_IV_SLOT2:  iv_nxt = SFD_IV_XFER;
         SFD_IV_XFER:   iv_nxt = SFD_IV_PRESET;
         default:       iv_nxt = SFD_IV_PRESET;
      endcase
   end

   // Rising half of divided clock
   wire div_hi   = (iv_nxt == SFD_IV_SLOT2) | (iv_nxt == SFD_IV_XFER);
   wire div_rise = rclk_rise & (iv_nxt == SFD_IV_SLOT2);

   // Interval, reference and phase registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         iv_r     <= SFD_IV_PRESET;
         div_r    <= 1'b0;
         pref_n_r <= 1'b1;
         phase_r  <= 1'b0;
      end else begin
         if (rclk_rise) begin
            iv_r  <= iv_nxt;
            div_r <= div_hi;
         end
         // RL13 reference on sync bits
         pref_n_r <= ~sync_bit;
         // RL15 set by reference, reset midway
         if (sync_bit) begin
            phase_r <= 1'b1;
         end else if (div_rise) begin
            phase_r <= 1'b0;
         end
      end
   end

   // =====================================================
   // Peak detect gate phasing
   // =====================================================
   logic alt_r;          // Position bit alternation
   logic pre_g_r;        // Preset gate
   logic pka_r;          // Peak A gate
   logic pkb_r;          // Peak B gate
   logic xfr_r;          // Transfer gate

   wire slot1 = (iv_r == SFD_IV_SLOT1);
   wire slot2 = (iv_r == SFD_IV_SLOT2);
   // RL12 slope swaps gates
   wire a_sel = alt_r ^ slope_lvl;

   // Gate generation
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alt_r   <= 1'b0;
         pre_g_r <= 1'b0;
         pka_r   <= 1'b0;
         pkb_r   <= 1'b0;
         xfr_r   <= 1'b0;
      end else begin
         // RL11 align after recognized code
         if (!valid_n_r) begin
            alt_r <= 1'b0;
         end else if (sync_bit) begin
            alt_r <= ~alt_r;
         end
         pre_g_r <= (iv_r == SFD_IV_PRESET);
         pka_r   <= a_sel ? slot2 : slot1;
         pkb_r   <= a_sel ? slot1 : slot2;
         xfr_r   <= (iv_r == SFD_IV_XFER);
      end
   end

   // =====================================================
   // Outputs
   // =====================================================
   assign index_en                = idx_en_r;
   assign valid_decode_n          = valid_n_r;
   assign outer_gb_n              = ogb_n_r;
   assign inner_gb_n              = igb_n_r;
   assign index_out               = index_r;
   assign sector_out              = sec_if.sector;
   assign phase_ref_pulse_n       = pref_n_r;
   assign divided_sync_rate_clock = div_r;
   assign phase_ff                = phase_r;
   assign preset_gate             = pre_g_r;
   assign peak_a_gate             = pka_r;
   assign peak_b_gate             = pkb_r;
   assign xfer_gate               = xfr_r;
endmodule

// ==== testbench/sfd_chk_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker for servo format decode
// ==========================================
module sfd_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic index_en,
   input wire logic valid_decode_n,
   input wire logic outer_gb_n,
   input wire logic inner_gb_n,
   input wire logic index_out,
   input wire logic sector_out,
   input wire logic phase_ref_pulse_n,
   input wire logic divided_sync_rate_clock,
   input wire logic phase_ff,
   input wire logic peak_a_gate,
   input wire logic peak_b_gate
);
   logic [7:0] hi_cnt_r;    // Cycles index level high
   logic [7:0] since_idx_r; // Cycles since index decode

   // Saturating helper counters
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hi_cnt_r    <= 8'h00;
         since_idx_r <= 8'hFF;
      end else begin
         hi_cnt_r    <= index_out ? hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF} : 8'h00;
         since_idx_r <= index_en ? 8'h00 : since_idx_r + {7'h00, since_idx_r != 8'hFF};
      end
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // One-cycle pulse shapes
   sequence idx_pulse_s;
      index_en ##1 !index_en;
   endsequence
   sequence sec_pulse_s;
      sector_out ##1 !sector_out;
   endsequence

   // ==========================================
   // Decoder outputs
   // ==========================================
   index_decode_a: assert property (index_en |-> !valid_decode_n && outer_gb_n && inner_gb_n)
      else $error("index pulse without recognized code");
   index_pulse_a: assert property (index_en |-> idx_pulse_s)
      else $error("index pulse longer than one cycle");
   outer_decode_a: assert property (!outer_gb_n |-> !valid_decode_n && !index_en && inner_gb_n)
      else $error("outer guard pulse without recognized code");
   inner_decode_a: assert property (!inner_gb_n |-> !valid_decode_n && !index_en)
      else $error("inner guard pulse without recognized code");
   decode_pulse_a: assert property ($fell(valid_decode_n) |=> valid_decode_n)
      else $error("recognized pulse longer than one cycle");

   // ==========================================
   // Index stretch, phase and sector
   // ==========================================
   stretch_len_a: assert property (hi_cnt_r <= 8'd101)
      else $error("index level held too long");
   latch_cause_a: assert property ($rose(index_out) |-> since_idx_r <= 8'd102)
      else $error("index level set without recent decode");
   gate_excl_a: assert property (!(peak_a_gate && peak_b_gate))
      else $error("both peak gates active");
   phase_set_a: assert property (!phase_ref_pulse_n |-> phase_ff)
      else $error("phase flop not set by reference");
   phase_reset_a: assert property ($rose(divided_sync_rate_clock) && phase_ref_pulse_n |-> !phase_ff)
      else $error("phase flop not cleared at divided clock rise");
   sector_pulse_a: assert property (sector_out |-> sec_pulse_s)
      else $error("sector pulse longer than one cycle");
endmodule

bind sfd_top sfd_chk sfd_chk_inst (
   .clk(clk), .rst_n(rst_n), .index_en(index_en), .valid_decode_n(valid_decode_n),
   .outer_gb_n(outer_gb_n), .inner_gb_n(inner_gb_n), .index_out(index_out),
   .sector_out(sector_out), .phase_ref_pulse_n(phase_ref_pulse_n), .phase_ff(phase_ff),
   .peak_a_gate(peak_a_gate), .peak_b_gate(peak_b_gate),
   .divided_sync_rate_clock(divided_sync_rate_clock));

// ==== testbench/sfd_servo_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Servo stream and processor model
// ==========================================
module sfd_servo_model (
   input  wire logic clk,
   output logic      zero_cross_det,
   output logic      sync_slot,
   output logic      servo_data_clk,
   output logic      tribit_clk,
   output logic      rec_clk,
   output logic      servo_clk,
   output logic      slope_sel
);
   logic [1:0] rdiv = 2'h0; // Recovered clock divider
   logic [1:0] sdiv = 2'h0; // Servo clock divider

   initial begin
      {zero_cross_det, sync_slot, servo_data_clk, tribit_clk} = 4'h0;
      {rec_clk, servo_clk, slope_sel} = 3'h0;
   end

   always @(posedge clk) begin
      rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
      sdiv <= sdiv + 2'h1;
      if (rdiv == 2'h2) rec_clk <= !rec_clk;
      if (sdiv[0]) servo_clk <= !servo_clk;
   end

   // Wait a few clocks
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One detection, slot set first
   task automatic detect(input logic slot);
      sync_slot <= slot;
      hold(4);
      zero_cross_det <= 1'b1;
      hold(4);
      zero_cross_det <= 1'b0;
      hold(4);
   endtask

   // sync always, data bit on index byte
   task automatic send_byte(input logic idx);
      detect(1'b1);
      if (idx) detect(1'b0);
      servo_data_clk <= 1'b1;
      hold(4);
      servo_data_clk <= 1'b0;
      hold(4);
      tribit_clk <= 1'b1;
      hold(4);
      tribit_clk <= 1'b0;
      hold(4);
   endtask

   // Flush with normal bytes, then code oldest first
   task automatic send_code(input logic [4:0] c);
      for (int i = 0; i < 5; i++) send_byte(1'b0);
      for (int i = 4; i >= 0; i--) send_byte(c[i]);
   endtask

   // processor sets slope at a seek
   task automatic set_slope(input logic s);
      slope_sel <= s;
      hold(20);
   endtask
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED at %0t got %0h expected %0h", $time, (a), (e)); end end
// ==========================================
// Servo format decode bench
// ==========================================
module testbench;
   import sfd_pkg::*;
   localparam logic [SEC_W-1:0] PRESET = 12'hFF0;
   localparam int               TICK   = 48; // Clocks per byte tick
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   logic [SEC_W-1:0] sector_preset = PRESET;
   logic zc, slot, sdc, win, rclk, sclk, slope;
   logic idx_en, vd_n, ogb_n, igb_n, idx_out, sec, ph_n, dclk, ph_ff, pre_g, pa_g, pb_g, xf_g;
   logic pre_q, pa_q, rec_q, div_q, io_q, pa_after_pre;
   int   bad_count, checks_done, cyc, sec_t, sec_gap, rise_t;
   int   n_idx, n_vd, n_ogb, n_igb, n_ph, n_sec, n_hi, n_rec, n_div, n_pa, n_xf, n_pb;

   always #12.5 clk = ~clk;

   sfd_servo_model sfd_servo_model_inst (.clk(clk), .zero_cross_det(zc), .sync_slot(slot),
      .servo_data_clk(sdc), .tribit_clk(win), .rec_clk(rclk), .servo_clk(sclk), .slope_sel(slope));
   sfd_top sfd_top_inst (.clk(clk), .rst_n(rst_n), .zero_cross_det(zc), .sync_slot(slot),
      .servo_data_clk(sdc), .tribit_clk(win), .slope_sel(slope), .rec_clk(rclk), .servo_clk(sclk),
      .sector_preset(sector_preset), .index_en(idx_en), .valid_decode_n(vd_n), .outer_gb_n(ogb_n),
      .inner_gb_n(igb_n), .index_out(idx_out), .sector_out(sec), .phase_ref_pulse_n(ph_n),
      .divided_sync_rate_clock(dclk), .phase_ff(ph_ff), .preset_gate(pre_g), .peak_a_gate(pa_g),
      .peak_b_gate(pb_g), .xfer_gate(xf_g));

   // Event counters on the outputs
   always @(posedge clk) begin
      cyc++;
      if (rst_n) begin
         n_idx += (idx_en === 1'b1);
         n_vd  += (vd_n === 1'b0);
         n_ogb += (ogb_n === 1'b0);
         n_igb += (igb_n === 1'b0);
         n_ph  += (ph_n === 1'b0);
         n_hi  += (idx_out === 1'b1);
         n_rec += (rclk && !rec_q);
         n_div += (dclk === 1'b1 && !div_q);
         n_xf  += (xf_g === 1'b1);
         n_pb  += (pb_g === 1'b1);
         if (sec === 1'b1) begin
            sec_gap = cyc - sec_t;
            sec_t = cyc;
            n_sec++;
         end
         if (idx_out === 1'b1 && !io_q) rise_t = cyc;
         if (pa_g === 1'b1 && !pa_q) begin
            pa_after_pre = pre_q;
            n_pa++;
         end
      end
      {pre_q, pa_q, rec_q, div_q, io_q} = {pre_g, pa_g, rclk, dclk, idx_out};
   end

   // Every code plus one unknown pattern
   task automatic t_codes;
      logic [4:0] code [5] = '{PAT_IDX, PAT_OGB, PAT_IGB, PAT_DATA, 5'h13};
      int a, v, o, g, p, h;
      for (int k = 0; k < 5; k++) begin
         {a, v, o, g, p, h} = {n_idx, n_vd, n_ogb, n_igb, n_ph, n_hi};
         sfd_servo_model_inst.send_code(code[k]);
         repeat (130) @(posedge clk);
         `CHK(n_idx - a, int'(code[k] == PAT_IDX))
         `CHK(n_vd - v, int'(k < 4))
         `CHK(n_ogb - o, int'(code[k] == PAT_OGB))
         `CHK(n_igb - g, int'(code[k] == PAT_IGB))
         `CHK(n_ph - p, 10)
         `CHK((n_hi - h >= 40) && (n_hi - h <= 100), code[k] == PAT_IDX)
      end
   endtask

   // Wait for more sector pulses, bounded
   task automatic wait_sec(input int n);
      int s;
      s = n_sec;
      for (int k = 0; k < 5000 && n_sec < s + n; k++) @(posedge clk);
   endtask

   // Sector period and restart by index
   task automatic t_sector;
      wait_sec(2);
      `CHK(sec_gap, (4096 - int'(PRESET)) * TICK)
      sfd_servo_model_inst.send_code(PAT_IDX);
      repeat (60) @(posedge clk);
      wait_sec(1);
      `CHK((sec_t - rise_t >= 15 * TICK - 5) && (sec_t - rise_t <= 15 * TICK + 4), 1'b1)
   endtask

   // Gate slots and divided clock
   task automatic t_gates;
      int k, r, d, x, b;
      for (int s = 0; s < 2; s++) begin
         sfd_servo_model_inst.set_slope(s[0]);
         k = n_pa;
         for (int w = 0; w < 100 && n_pa == k; w++) @(posedge clk);
         `CHK(pa_after_pre, !s[0])
      end
      {r, d, x, b} = {n_rec, n_div, n_xf, n_pb};
      repeat (480) @(posedge clk);
      `CHK(((n_div - d) * 4 >= n_rec - r - 4) && ((n_div - d) * 4 <= n_rec - r + 4), 1'b1)
      `CHK((n_xf - x >= 114) && (n_xf - x <= 126), 1'b1)
      `CHK((n_pb - b >= 114) && (n_pb - b <= 126), 1'b1)
   endtask

   // Verdict and end of run
   task automatic results;
      if (bad_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_codes;
      t_sector;
      t_gates;
      results;
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      results;
   end
endmodule
